/* rtl/wire_chamber_readout_control.sv */
// Readout control, status and event formatting for a four-stream wire-chamber module.
// Assumes stream data changes on the returned stream-0 clock, sampled here by mclk.
`timescale 1ns/1ps
// Functional notes
// - Mode 0 normal, 1 test echoed to cards, 2 configuration, 3 calibration.
// - Calibration pin drives streams to mode 3; mode readback keeps written value.
// - Stream select matters only in mode 2; other streams forced to mode 0.
// - Entering configuration mode discards buffered pages and output words.
// - Four-bit board tag appears in every event header.
// - Clock failure on stream-0 clock timeout or stray edges while idle.
// - Clock failure sticks until reset or soft reset and blocks all readout requests.
// - With run, failure drives bus; failure removes no-current-data from bus.
// - No-current-data sets on header read, clears when next event waits.
// - Full flag when fifteen of sixteen pages used; busy then asserted too.
// - Busy while a stream readout runs or buffer is full.
// - Five-bit board count per stream; zero disables, fewer truncates chain.
// - Stream-0 clock times all streams; counts unused for configuration.
// - Page pointers clear on reset; equal pointers mean pages empty.
// - Finished readout advances write page, copies page out, then read page.
// - 32-bit data read gives earlier word high, later word low.
// - Mixed 16/32-bit reads allowed; counts always in 16-bit words.
// - Header: word count 7-0, page 11-8, tag 15-12.
// - Read with no valid event returns header with count zero.
// - Hit word: mask 7-0, chip 12-8, stream 14-13, bit 15 zero.
// - Parity word: zero 7-0, chip 11-8, stream 14-13, bit 15 zero.
module wire_chamber_readout_control
  import readout_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic        regD32,
  input  wire logic [15:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        streamClk0,
  input  wire logic [3:0]  streamData,
  input  wire logic        readoutRequestPulse,
  input  wire logic        abortPin,
  input  wire logic        calibratePin,
  output logic      [7:0]  streamMode,
  output logic             configFetchPulse,
  output logic             configStorePulse,
  output logic             readoutActive,
  output logic             cmdNcdOut,
  output logic             cmdNcdOe,
  output logic             cmdFailOut,
  output logic             cmdFailOe,
  output logic             busy
);
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_STORE, RD_CLOSE} rd_state_t;
  typedef enum logic [1:0] {CP_IDLE, CP_HEAD, CP_BODY} cp_state_t;

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Pin synchronisers: a rise counts once the second and third stages agree; a fall counts as soon as they differ
  logic [7:0] syncA_q, syncB_q, syncC_q, pinF_q, pinPrev_q;
  logic [7:0] pinRaw;
  assign pinRaw = {calibratePin, abortPin, readoutRequestPulse, streamData, streamClk0};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_q   <= 8'h00;
      syncB_q   <= 8'h00;
      syncC_q   <= 8'h00;
      pinF_q    <= 8'h00;
      pinPrev_q <= 8'h00;
    end else begin
      syncA_q   <= pinRaw;
      syncB_q   <= syncA_q;
      syncC_q   <= syncB_q;
      pinF_q    <= (pinF_q & ~(syncB_q ^ syncC_q)) | (syncB_q & ~(syncB_q ^ syncC_q));
      pinPrev_q <= pinF_q;
    end
  end

  logic       sclkEdge, rdPinEdge, abortEdge, calLevel;
  logic [3:0] sData;
  assign sclkEdge  = pinF_q[0] && !pinPrev_q[0];
  assign sData     = pinF_q[4:1];
  assign rdPinEdge = pinF_q[5] && !pinPrev_q[5];
  assign abortEdge = pinF_q[6] && !pinPrev_q[6];
  assign calLevel  = pinF_q[7];

  // Register port decode
  logic wrMode, wrPage, wrPulse, wrBcnt, rdData;
  assign wrMode  = regWr && isReg(regAddr, ADDR_MODE);
  assign wrPage  = regWr && isReg(regAddr, ADDR_PAGE);
  assign wrPulse = regWr && isReg(regAddr, ADDR_PULSE);
  assign wrBcnt  = regWr && isReg(regAddr & ~BCNT_IDX_MASK, ADDR_BCNT0);
  assign rdData  = regRd && isReg(regAddr, ADDR_DATA);

  logic [1:0] mode_q, sel_q;
  logic       run_q;
  logic [3:0] tag_q;
  logic [4:0] bcnt_q [4];
  logic       softRst;
  logic       enterConfig;

  assign softRst     = wrPulse && regWdata[PULSE_CLEAR];
  assign enterConfig = wrMode && regWdata[SEL_LO-1:MODE_LO] == MODE_CONFIG
                       && mode_q != MODE_CONFIG;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_NORMAL;
      sel_q  <= 2'h0;
      run_q  <= 1'b0;
      tag_q  <= 4'h0;
      for (int s = 0; s < 4; s++) bcnt_q[s] <= 5'h00;
    end else if (softRst) begin
      mode_q <= MODE_NORMAL;
      sel_q  <= 2'h0;
      run_q  <= 1'b0;
      tag_q  <= 4'h0;
    end else begin
      if (wrMode) begin
        mode_q <= regWdata[SEL_LO-1:MODE_LO];
        sel_q  <= regWdata[RUN_BIT-1:SEL_LO];
        run_q  <= regWdata[RUN_BIT];
        tag_q  <= regWdata[TAG_LO+3:TAG_LO];
      end
      if (wrBcnt) begin
        bcnt_q[regAddr[3:2]] <= regWdata[4:0];
      end
    end
  end

  // Stream modes: calibration overrides, configuration isolates the selected stream
  for (genvar s = 0; s < 4; s++) begin : g_smode
    logic [1:0] m;
    assign m = calLevel ? MODE_CAL :
               (mode_q == MODE_CONFIG) ? (sel_q == s ? MODE_CONFIG : MODE_NORMAL) :
               mode_q;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        streamMode[2*s+1:2*s] <= MODE_NORMAL;
      end else begin
        streamMode[2*s+1:2*s] <= m;
      end
    end
  end

  // Page pointers, full and readout control
  logic [3:0] rp_q, wp_q;
  logic       full, fail_q, ncd_q;
  rd_state_t  rdState_q;
  cp_state_t  cpState_q;
  logic [3:0] bitCnt_q;
  logic [5:0] chipCnt_q, chipMax;
  logic [1:0] storeIdx_q;
  logic [7:0] wordIdx_q;
  logic [9:0] timer_q;
  logic [8:0] shift_q [4];
  logic       abortReq, rdReq, rdStart, timeout, stray, dropEvent, storeWr;

  // Stream length is the longest enabled chain, two chips per board
  function automatic logic [5:0] chips(input logic [4:0] b);
    return {b, 1'b0};
  endfunction
  assign chipMax = (chips(bcnt_q[0]) > chips(bcnt_q[1]) ?
                    chips(bcnt_q[0]) : chips(bcnt_q[1])) >
                   (chips(bcnt_q[2]) > chips(bcnt_q[3]) ? chips(bcnt_q[2]) : chips(bcnt_q[3]))
                   ? (chips(bcnt_q[0]) > chips(bcnt_q[1]) ? chips(bcnt_q[0]) : chips(bcnt_q[1]))
                   : (chips(bcnt_q[2]) > chips(bcnt_q[3]) ? chips(bcnt_q[2]) : chips(bcnt_q[3]));

  assign full      = (wp_q + 4'h1) == rp_q;
  assign busy      = rdState_q != RD_IDLE || full;
  assign abortReq  = abortEdge || (wrPulse && regWdata[PULSE_ABORT]) || fail_q;
  assign rdReq     = rdPinEdge || (wrPulse && regWdata[PULSE_READOUT_REQUEST_PULSE]);
  assign rdStart   = rdReq && run_q && !busy && !abortReq
                     && mode_q != MODE_CONFIG && rdState_q == RD_IDLE;
  assign timeout   = rdState_q == RD_WAIT && !sclkEdge && timer_q == TIMEOUT_CYC;
  assign stray     = rdState_q == RD_IDLE && sclkEdge;
  assign dropEvent = abortReq || enterConfig || softRst;
  assign readoutActive = rdState_q != RD_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fail_q <= 1'b0;
    end else if (timeout || stray) begin
      fail_q <= 1'b1;                     // set wins over a clear in the same cycle
    end else if (softRst) begin
      fail_q <= 1'b0;
    end
  end

  // Stream-0 clock times every stream; board counts set the readout length and gate which chips are kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdState_q  <= RD_IDLE;
      bitCnt_q   <= 4'h0;
      chipCnt_q  <= 6'h00;
      storeIdx_q <= 2'h0;
      wordIdx_q  <= 8'h00;
      timer_q    <= 10'h000;
      for (int s = 0; s < 4; s++) shift_q[s] <= 9'h000;
    end else begin
      case (rdState_q)
        RD_IDLE: begin
          if (rdStart) begin
            rdState_q <= (chipMax == 6'h00) ? RD_CLOSE : RD_WAIT;
            bitCnt_q  <= 4'h0;
            chipCnt_q <= 6'h00;
            wordIdx_q <= 8'h00;
            timer_q   <= 10'h000;
          end
        end
        RD_WAIT: begin
          if (dropEvent || timeout) begin
            rdState_q <= RD_IDLE;
          end else if (sclkEdge) begin
            timer_q <= 10'h000;
            for (int s = 0; s < 4; s++) shift_q[s] <= {shift_q[s][7:0], sData[s]};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == LAST_BIT) begin
              rdState_q  <= RD_STORE;
              storeIdx_q <= 2'h0;
            end
          end else begin
            timer_q <= timer_q + 10'h001;
          end
        end
        RD_STORE: begin
          // Stray stream-0 edges here are not counted: four store cycles fit in one bit period
          if (dropEvent) begin
            rdState_q <= RD_IDLE;
          end else begin
            if (storeWr) wordIdx_q <= wordIdx_q + 8'h01;
            storeIdx_q <= storeIdx_q + 2'h1;
            if (storeIdx_q == 2'h3) begin
              chipCnt_q <= chipCnt_q + 6'h01;
              bitCnt_q  <= 4'h0;
              timer_q   <= 10'h000;
              rdState_q <= (chipCnt_q + 6'h01 == chipMax) ? RD_CLOSE : RD_WAIT;
            end
          end
        end
        RD_CLOSE: begin
          rdState_q <= RD_IDLE;
        end
        default: rdState_q <= RD_IDLE;
      endcase
    end
  end

  // Word assembly for the stream in turn
  logic        parErr, chipOn;
  logic [8:0]  cur;
  logic [15:0] storeWord;
  assign cur       = shift_q[storeIdx_q];
  assign chipOn    = chipCnt_q < chips(bcnt_q[storeIdx_q]);
  assign parErr    = ^cur;
  assign storeWr   = rdState_q == RD_STORE && !dropEvent && chipOn
                     && (parErr || cur[8:1] != 8'h00) && wordIdx_q != PAGE_WORDS;
  assign storeWord = parErr ? {1'b0, storeIdx_q, 1'b0, chipCnt_q[3:0], 8'h00}
                            : {1'b0, storeIdx_q, chipCnt_q[4:0], cur[8:1]};

  logic [15:0] pageMem [2048];
  logic [7:0]  pageCnt [16];
  always_ff @(posedge mclk) begin
    if (storeWr) pageMem[{wp_q, wordIdx_q[6:0]}] <= storeWord;
    if (rdState_q == RD_CLOSE) pageCnt[wp_q] <= wordIdx_q;
  end

  // Page copier feeding the two-entry buffer
  evbuf_if ebuf (.clk(mclk), .rst(rst));
  event_word_buffer u_buf (.port(ebuf.store));

  logic [7:0]  cpIdx_q;
  logic [15:0] header;
  logic        cpPush, cpDone;
  assign header = {tag_q, rp_q, pageCnt[rp_q] + 8'h01};
  assign ebuf.pushValid = cpState_q != CP_IDLE && !dropEvent;
  assign ebuf.pushData  = cpState_q == CP_HEAD ? {1'b1, header}
                                                : {1'b0, pageMem[{rp_q, cpIdx_q[6:0]}]};
  assign cpPush = ebuf.pushValid && ebuf.pushReady;
  assign cpDone = (cpState_q == CP_HEAD && pageCnt[rp_q] == 8'h00) ||
                  (cpState_q == CP_BODY && cpIdx_q + 8'h01 == pageCnt[rp_q]);
  assign ebuf.flush = enterConfig || softRst || abortReq;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rp_q      <= 4'h0;
      wp_q      <= 4'h0;
      cpState_q <= CP_IDLE;
      cpIdx_q   <= 8'h00;
    end else if (dropEvent) begin
      // Every abort empties the pages too, so the copier never resumes mid-event
      rp_q      <= softRst ? 4'h0 : wp_q;
      wp_q      <= softRst ? 4'h0 : wp_q;
      cpState_q <= CP_IDLE;
    end else if (wrPage) begin
      rp_q <= regWdata[PTR_W-1:0];
      wp_q <= regWdata[2*PTR_W-1:PTR_W];
    end else begin
      if (rdState_q == RD_CLOSE) wp_q <= wp_q + 4'h1;
      case (cpState_q)
        CP_IDLE: begin
          if (rp_q != wp_q && mode_q != MODE_CONFIG) begin
            cpState_q <= CP_HEAD;
            cpIdx_q   <= 8'h00;
          end
        end
        CP_HEAD, CP_BODY: begin
          if (cpPush) begin
            if (cpDone) begin
              cpState_q <= CP_IDLE;
              rp_q      <= rp_q + 4'h1;
            end else begin
              cpState_q <= CP_BODY;
              if (cpState_q == CP_BODY) cpIdx_q <= cpIdx_q + 8'h01;
            end
          end
        end
        default: cpState_q <= CP_IDLE;
      endcase
    end
  end

  // Data register reads: 32-bit reads take two words, earlier one high
  logic [15:0] emptyHdr, word0, word1;
  logic        hdrPop;
  assign emptyHdr   = {tag_q, rp_q, 8'h00};
  assign word0      = ebuf.popValid ? ebuf.popData[WORD_W-1:0] : emptyHdr;
  assign word1      = ebuf.popValid2 ? ebuf.popData2[WORD_W-1:0] : emptyHdr;
  assign ebuf.popOne = rdData && ebuf.popValid && !(regD32 && ebuf.popValid2);
  assign ebuf.popTwo = rdData && regD32 && ebuf.popValid2;
  assign hdrPop     = rdData && ebuf.popValid && ebuf.popData[WORD_W];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ncd_q <= 1'b1;
    end else if (hdrPop || ebuf.flush) begin
      ncd_q <= 1'b1;
    end else if (ebuf.popValid && ebuf.popData[WORD_W]) begin
      ncd_q <= 1'b0;
    end
  end

  logic [31:0] rdMux;
  assign rdMux = rdData ? (regD32 ? {word0, word1} : {16'h0000, word0}) :
                 isReg(regAddr, ADDR_MODE) ?
                   {16'h0000, busy, 1'b0, full, ncd_q, tag_q, fail_q, 2'h0, run_q, sel_q,
                    mode_q} :
                 isReg(regAddr, ADDR_PAGE) ? {24'h000000, wp_q, rp_q} :
                 isReg(regAddr & ~BCNT_IDX_MASK, ADDR_BCNT0) ?
                   {27'h0000000, bcnt_q[regAddr[3:2]]} : 32'h00000000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata         <= 32'h00000000;
      configFetchPulse <= 1'b0;
      configStorePulse <= 1'b0;
    end else begin
      if (regRd) regRdata <= rdMux;
      configFetchPulse <= wrPulse && regWdata[PULSE_FETCH];
      // Abort while idle clears events held in the cards
      configStorePulse <= (wrPulse && regWdata[PULSE_STORE]) ||
                          ((abortEdge || (wrPulse && regWdata[PULSE_ABORT])) &&
                           rdState_q == RD_IDLE);
    end
  end

  // Wired-OR command bus lines, driven high only when asserted
  assign cmdFailOut = 1'b1;
  assign cmdFailOe  = run_q && fail_q;
  assign cmdNcdOut  = 1'b1;
  assign cmdNcdOe   = run_q && ncd_q && !fail_q;

  sequence s_close;
    rdState_q == RD_CLOSE;
  endsequence

  property p_failSticky;
    @(posedge mclk) disable iff (rst) fail_q && !softRst |=> fail_q;
  endproperty
  a_failSticky: assert property (p_failSticky) else $error("failure flag dropped");

  property p_failBlocks;
    @(posedge mclk) disable iff (rst) fail_q && rdState_q == RD_IDLE |=> rdState_q == RD_IDLE;
  endproperty
  a_failBlocks: assert property (p_failBlocks) else $error("readout began under failure");

  property p_timeout;
    @(posedge mclk) disable iff (rst) timeout |=> fail_q && rdState_q == RD_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_busGate;
    @(posedge mclk) disable iff (rst) !run_q |-> !cmdNcdOe && !cmdFailOe;
  endproperty
  a_busGate: assert property (p_busGate) else $error("bus driven without run");

  property p_ncdOff;
    @(posedge mclk) disable iff (rst) fail_q |-> !cmdNcdOe && (cmdFailOe == run_q);
  endproperty
  a_ncdOff: assert property (p_ncdOff) else $error("bus state wrong on failure");

  property p_cal;
    @(posedge mclk) disable iff (rst) calLevel ##1 calLevel |-> streamMode == 8'hff;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration mode not driven");

  property p_cfgIso;
    @(posedge mclk) disable iff (rst)
      mode_q == MODE_CONFIG && sel_q != 2'h0 && !calLevel ##1 $stable(mode_q)
      |-> streamMode[1:0] == MODE_NORMAL;
  endproperty
  a_cfgIso: assert property (p_cfgIso) else $error("unselected stream not normal");

  property p_busyFull;
    @(posedge mclk) disable iff (rst) full |-> busy && !rdStart;
  endproperty
  a_busyFull: assert property (p_busyFull) else $error("full without busy");

  property p_pageAdv;
    @(posedge mclk) disable iff (rst) s_close ##0 !dropEvent && !wrPage
      |=> wp_q == $past(wp_q) + 4'h1;
  endproperty
  a_pageAdv: assert property (p_pageAdv) else $error("write page not advanced");

  property p_ncdSet;
    @(posedge mclk) disable iff (rst) hdrPop |=> ncd_q;
  endproperty
  a_ncdSet: assert property (p_ncdSet) else $error("header read left flag clear");

  property p_emptyRead;
    @(posedge mclk) disable iff (rst) rdData && !ebuf.popValid && !regD32
      |=> regRdata[7:0] == 8'h00 && regRdata[15:12] == $past(tag_q);
  endproperty
  a_emptyRead: assert property (p_emptyRead) else $error("empty read count nonzero");
endmodule // wire_chamber_readout_control

/* rtl/readout_pkg.sv */
// Constants shared by the wire-chamber readout control block and its buffer.
// Assumes one 250 MHz module clock; the register port is the module's own strobe port.
package readout_pkg;
  // Register offsets (byte addresses on the module port)
  localparam logic [7:0] ADDR_BCNT0     = 8'h00;
  localparam logic [7:0] BCNT_IDX_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_MODE      = 8'h10;
  localparam logic [7:0] ADDR_PAGE      = 8'h14;
  localparam logic [7:0] ADDR_DATA      = 8'h20;
  localparam logic [7:0] ADDR_PULSE     = 8'h28;

  // Operating modes
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_TEST      = 2'h1;
  localparam logic [1:0] MODE_CONFIG    = 2'h2;
  localparam logic [1:0] MODE_CAL       = 2'h3;

  // Pulse register bit positions
  localparam int PULSE_CLEAR  = 0;
  localparam int PULSE_FETCH  = 1;
  localparam int PULSE_STORE  = 2;
  localparam int PULSE_READOUT_REQUEST_PULSE  = 3;
  localparam int PULSE_ABORT  = 4;

  // Mode and page register write fields
  localparam int MODE_LO = 0;
  localparam int SEL_LO  = 2;
  localparam int RUN_BIT = 4;
  localparam int TAG_LO  = 8;
  localparam int PTR_W   = 4;

  // Stream framing: eight hit bits then one parity bit per chip
  localparam logic [3:0] LAST_BIT   = 4'h8;
  localparam int         WORD_W     = 16;
  localparam logic [7:0] PAGE_WORDS = 8'h80;

  // Stream-0 clock timeout
  localparam int         CLK_PERIOD_PS = 4000;
  localparam int         TIMEOUT_NS    = 2000;
  localparam logic [9:0] TIMEOUT_CYC   = 10'((TIMEOUT_NS * 1000) / CLK_PERIOD_PS);

  typedef logic [WORD_W:0] entry_t;   // {isHeader, word}
endpackage

/* rtl/evbuf_if.sv */
// Carrier between the readout control and its two-entry event word buffer.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface evbuf_if
  import readout_pkg::*;
(
  input wire logic clk,
  input wire logic rst
);
  logic   pushValid;
  logic   pushReady;
  entry_t pushData;
  logic   popValid;
  logic   popValid2;
  entry_t popData;
  entry_t popData2;
  logic   popOne;
  logic   popTwo;
  logic   flush;

  modport store (input clk, rst, pushValid, pushData, popOne, popTwo, flush,
                 output pushReady, popValid, popValid2, popData, popData2);
  modport user  (output pushValid, pushData, popOne, popTwo, flush,
                 input pushReady, popValid, popValid2, popData, popData2);
endinterface

/* rtl/event_word_buffer.sv */
// Two-entry word buffer between the page copier and the data register.
// Assumes the consumer pops only valid entries; popTwo needs both valid.
`timescale 1ns/1ps
module event_word_buffer
  import readout_pkg::*;
(
  evbuf_if.store port
);
  entry_t     slot_q [2];
  logic [1:0] count_q;
  logic [1:0] popN;
  logic       push;

  assign popN           = port.popTwo ? 2'h2 : (port.popOne ? 2'h1 : 2'h0);
  // A slot frees up in the same cycle it is popped, so reads never stall the copier twice
  assign port.pushReady = (count_q - popN) != 2'h2;
  assign push           = port.pushValid && port.pushReady;
  assign port.popValid  = count_q != 2'h0;
  assign port.popValid2 = count_q == 2'h2;
  assign port.popData   = slot_q[0];
  assign port.popData2  = slot_q[1];

  always_ff @(posedge port.clk or posedge port.rst) begin
    if (port.rst) begin
      count_q <= 2'h0;
    end else if (port.flush) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_q - popN + {1'b0, push};
    end
  end

  always_ff @(posedge port.clk) begin
    if (popN == 2'h1) begin
      slot_q[0] <= (push && count_q == 2'h1) ? port.pushData : slot_q[1];
    end else if (push && (count_q == popN)) begin
      slot_q[0] <= port.pushData;
    end
    if (push && (count_q - popN) == 2'h1) begin
      slot_q[1] <= port.pushData;
    end
  end
endmodule // event_word_buffer

/* verif/chamber_chain.sv */
// Stream-0 chain of two chips, answering each start with one frame.
// Assumes start rises once per frame; other streams carry no hits.
`timescale 1ns/1ps
module chamber_chain (
  input  wire logic       start,
  output logic            clk0,
  output logic [3:0]      data
);
  // Second chip answers with a lone parity bit, i.e. a transmission error
  logic [8:0] chip [2] = '{9'h14a, 9'h001};
  initial begin
    clk0 = 1'b0;
    data = 4'h0;
  end
  // Clock stands still between frames; data flips so stale bits never look valid
  always @(posedge start) begin
    // Keep every pin change at least 1 ns off the rising module clock edge so sampling never races
    #1;
    for (int c = 0; c < 2; c++) begin
      for (int b = 8; b >= 0; b--) begin
        data <= {3'h0, chip[c][b]};
        #16 clk0 = 1'b1;
        #16 clk0 = 1'b0;
      end
    end
    data <= ~data;
  end
endmodule // chamber_chain

/* verif/tb_wire_chamber_readout_control.sv */
// Self-checking bench for the readout control block.
// Assumes the chamber chain model drives the stream pins.
`timescale 1ns/1ps
module tb_wire_chamber_readout_control;
  import readout_pkg::*;
  logic        mclk, rst, regWr, regRd, regD32, start, act, nOe, fOe, busy, calPin, reqPin;
  logic [7:0]  regAddr, sMode;
  logic [15:0] regWdata;
  logic [31:0] regRdata, rd;
  logic        clk0;
  logic [3:0]  sData;
  logic [7:0]  expM [3] = '{8'h00, 8'h55, 8'h08};
  int          n_errors, comparisons, i;
  chamber_chain chain (.start(start), .clk0(clk0), .data(sData));
  wire_chamber_readout_control dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regD32(regD32), .regWdata(regWdata),
    .regRdata(regRdata), .streamClk0(clk0), .streamData(sData),
    .readoutRequestPulse(reqPin), .abortPin(1'b0), .calibratePin(calPin),
    .streamMode(sMode), .configFetchPulse(), .configStorePulse(), .readoutActive(act),
    .cmdNcdOut(), .cmdNcdOe(nOe), .cmdFailOut(), .cmdFailOe(fOe), .busy(busy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, input logic w);
    @(posedge mclk);
    regAddr <= a;
    regD32 <= w;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic waitAct(input logic lvl);
    for (i = 0; i < 2000 && act !== lvl; i++) @(posedge mclk);
    if (i == 2000) begin
      n_errors++;
      results();
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {rst, regWr, regRd, regD32, regAddr, regWdata} = {4'h8, 24'h000000};
    {reqPin, calPin, start, n_errors, comparisons} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rdr(ADDR_MODE, 1'b0);
    chk(rd, 32'h00001000);
    rdr(ADDR_PAGE, 1'b0);
    chk(rd, 32'h00000000);
    wr(ADDR_BCNT0, 16'h001f);
    rdr(ADDR_BCNT0, 1'b0);
    chk(rd, 32'h0000001f);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_MODE, 16'h0304 | 16'(m));
      repeat (3) @(posedge mclk);
      chk(sMode, expM[m]);
    end
    wr(ADDR_BCNT0, 16'h0001);
    wr(ADDR_MODE, 16'h0310);
    calPin <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(sMode, 8'hff);
    rdr(ADDR_MODE, 1'b0);
    chk(rd[1:0], 2'h0);
    calPin <= 1'b0;
    rdr(ADDR_DATA, 1'b0);
    chk(rd[15:0], 16'h3000);
    $display("test registers done");
    reqPin <= 1'b1;
    repeat (4) @(posedge mclk);
    reqPin <= 1'b0;
    waitAct(1'b1);
    chk(busy, 1'b1);
    start <= 1'b1;
    waitAct(1'b0);
    start <= 1'b0;
    rd = '1;
    for (int k = 0; k < 50 && rd[12] !== 1'b0; k++) rdr(ADDR_MODE, 1'b0);
    chk(rd, 32'h00000310);
    // Hit word plus parity word: header counts three 16-bit words
    rdr(ADDR_DATA, 1'b1);
    chk(rd, 32'h300300a5);
    rdr(ADDR_DATA, 1'b0);
    chk(rd, 32'h00000100);
    rdr(ADDR_PAGE, 1'b0);
    chk(rd, 32'h00000011);
    rdr(ADDR_MODE, 1'b0);
    chk(rd, 32'h00001310);
    $display("test readout done");
    start <= 1'b1;
    repeat (200) @(posedge mclk);
    start <= 1'b0;
    rdr(ADDR_MODE, 1'b0);
    chk(rd[7], 1'b1);
    chk({fOe, nOe}, 2'b10);
    wr(ADDR_PULSE, 16'h0008);
    repeat (4) @(posedge mclk);
    chk(act, 1'b0);
    wr(ADDR_PULSE, 16'h0001);
    rdr(ADDR_MODE, 1'b0);
    chk(rd, 32'h00001000);
    // Run is clear after the soft reset: a request must be ignored, bus lines left alone
    wr(ADDR_PULSE, 16'h0008);
    repeat (4) @(posedge mclk);
    chk(act, 1'b0);
    chk({fOe, nOe}, 2'b00);
    $display("test failure done");
    results();
  end
endmodule // tb_wire_chamber_readout_control
